// [hw/esl_loader.sv]
// Implementation choice: strobed register access.
`timescale 1ns/100ps
// Operation
// - writing one to the update bit copies all buffer registers into the active ones.
// - that copy happens on the first rising clock edge after the write.
// - the update bit clears itself after it fires.
// - the segment table is a byte range holding start address and count of each block.
// - a command byte with its top bit clear is a data-transfer entry.
// - the low seven bits of a data entry are the byte count minus one.
// - the next two table bytes give the start address, high byte first.
// - a command byte with its top bit set is one of two opcodes, apply or end.
// - the apply opcode copies buffer to active registers like the update bit.
// - the end opcode stops the walk and ends the transfer.
// - after reset the table covers registers 0x000 to 0x232 and then applies.
// - setting the save request starts copying registers into storage by the table.
// - the status bit reads one while a save or restore runs and zero after.
module esl_loader
  import esl_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // register port
  input  wire esl_pkg::esl_bus_t bus,
  output logic      [7:0]        rdata,
  // configuration register space
  output esl_pkg::esl_cfg_t      cfg_req,
  input  wire logic [7:0]        cfg_rdata,
  output logic                   update_pulse,
  // nonvolatile storage
  output esl_pkg::esl_nvm_t      nvm_req,
  input  wire logic [7:0]        nvm_rdata,
  // status
  output logic                   busy
);
  import esl_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  esl_state_t            state_reg;
  esl_state_t            state_next;
  logic                  load_reg;
  logic                  load_next;
  logic [7:0]            idx_reg;
  logic [7:0]            idx_next;
  logic [6:0]            cnt_reg;
  logic [6:0]            cnt_next;
  logic [15:0]           addr_reg;
  logic [15:0]           addr_next;
  logic [ESL_NVM_AW-1:0] ptr_reg;
  logic [ESL_NVM_AW-1:0] ptr_next;
  esl_cfg_t              cfg_reg;
  esl_cfg_t              cfg_next;
  esl_nvm_t              nvm_reg;
  esl_nvm_t              nvm_next;
  logic                  busy_reg;
  logic                  busy_next;
  logic [7:0]            rdata_reg;
  logic [7:0]            rdata_next;

  logic                  tbl_hit_wr;
  logic                  tbl_hit_rd;
  logic [7:0]            tbl_host_rd;
  logic [7:0]            tbl_seq_rd;
  logic                  sw_update;
  logic                  seq_update;
  logic                  start_save;
  logic                  start_load;

  // ************************************************************
  // address decode
  // ************************************************************
  always_comb
  begin
    tbl_hit_wr = bus.we && (bus.addr >= ESL_ADDR_TBL_LO) && (bus.addr <= ESL_ADDR_TBL_HI);
    // read hit left ungated; the read-back mux only looks at it under re
    tbl_hit_rd = (bus.addr >= ESL_ADDR_TBL_LO) && (bus.addr <= ESL_ADDR_TBL_HI);
    sw_update  = bus.we && (bus.addr == ESL_ADDR_UPDATE) && bus.wdata[ESL_BIT_FLAG];
    // a request while a transfer runs is dropped, not queued
    start_save = bus.we && (bus.addr == ESL_ADDR_SAVE) && bus.wdata[ESL_BIT_FLAG]
                 && (state_reg == ESL_IDLE);
    start_load = bus.we && (bus.addr == ESL_ADDR_LOAD) && bus.wdata[ESL_BIT_FLAG]
                 && (state_reg == ESL_IDLE);
  end

  // ************************************************************
  // segment table and copy strobe
  // ************************************************************
  esl_seg_table u_table (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .we      (tbl_hit_wr),
    .waddr   (bus.addr[7:0]),
    .wdata   (bus.wdata),
    .raddr_a (bus.addr[7:0]),
    .rdata_a (tbl_host_rd),
    .raddr_b (idx_reg),
    .rdata_b (tbl_seq_rd)
  );

  esl_update_ctl u_update (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .sw_set      (sw_update),
    .seq_set     (seq_update),
    .apply_pulse (update_pulse)
  );

  // ************************************************************
  // register read-back
  // ************************************************************
  always_comb
  begin
    // zero outside the read slot keeps stale data off the port
    rdata_next = 8'h00;
    if (bus.re)
    begin
      if (tbl_hit_rd)
      begin
        rdata_next = tbl_host_rd;
      end
      else if (bus.addr == ESL_ADDR_UPDATE)
      begin
        rdata_next[ESL_BIT_FLAG] = update_pulse;
      end
      else if (bus.addr == ESL_ADDR_STATUS)
      begin
        rdata_next[ESL_BIT_FLAG] = busy_reg;
      end
      else if (bus.addr == ESL_ADDR_SAVE)
      begin
        rdata_next[ESL_BIT_FLAG] = busy_reg && !load_reg;
      end
      else if (bus.addr == ESL_ADDR_LOAD)
      begin
        rdata_next[ESL_BIT_FLAG] = busy_reg && load_reg;
      end
    end
  end

  // ************************************************************
  // table walker
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    load_next  = load_reg;
    idx_next   = idx_reg;
    cnt_next   = cnt_reg;
    addr_next  = addr_reg;
    ptr_next   = ptr_reg;
    cfg_next   = cfg_reg;
    nvm_next   = nvm_reg;
    cfg_next.we = 1'b0;
    cfg_next.re = 1'b0;
    nvm_next.we = 1'b0;
    nvm_next.re = 1'b0;
    // one table byte per cycle: slow, but needs no look-ahead
    seq_update = 1'b0;
    unique case (state_reg)
      ESL_IDLE:
      begin
        if (start_save || start_load)
        begin
          load_next  = start_load;
          idx_next   = 8'h00;
          ptr_next   = '0;
          state_next = ESL_CMD;
        end
      end
      ESL_CMD:
      begin
        if (!tbl_seq_rd[ESL_BIT_OPCODE])
        begin
          cnt_next   = tbl_seq_rd[ESL_BIT_OPCODE-1:0];
          idx_next   = idx_reg + 8'h01;
          state_next = (idx_reg == ESL_TBL_LAST) ? ESL_IDLE : ESL_AHI;
        end
        else if (tbl_seq_rd == ESL_OP_END)
        begin
          state_next = ESL_IDLE;
        end
        else
        begin
          // unknown opcodes are skipped like the apply opcode
          seq_update = (tbl_seq_rd == ESL_OP_APPLY);
          idx_next   = idx_reg + 8'h01;
          // table without an end opcode still stops at its last byte
          if (idx_reg == ESL_TBL_LAST)
          begin
            state_next = ESL_IDLE;
          end
        end
      end
      ESL_AHI:
      begin
        addr_next[15:8] = tbl_seq_rd;
        idx_next        = idx_reg + 8'h01;
        state_next      = (idx_reg == ESL_TBL_LAST) ? ESL_IDLE : ESL_ALO;
      end
      ESL_ALO:
      begin
        addr_next[7:0] = tbl_seq_rd;
        idx_next       = idx_reg + 8'h01;
        state_next     = (idx_reg == ESL_TBL_LAST) ? ESL_IDLE : ESL_RD;
      end
      ESL_RD:
      begin
        // save reads the register space, restore reads storage
        if (load_reg)
        begin
          nvm_next.re   = 1'b1;
          nvm_next.addr = ptr_reg;
        end
        else
        begin
          cfg_next.re   = 1'b1;
          cfg_next.addr = addr_reg[11:0];
        end
        state_next = ESL_WAIT;
      end
      ESL_WAIT:
      begin
        // read data are valid in the cycle after the strobe
        state_next = ESL_WR;
      end
      ESL_WR:
      begin
        if (load_reg)
        begin
          cfg_next.we    = 1'b1;
          cfg_next.addr  = addr_reg[11:0];
          cfg_next.wdata = nvm_rdata;
        end
        else
        begin
          nvm_next.we    = 1'b1;
          nvm_next.addr  = ptr_reg;
          nvm_next.wdata = cfg_rdata;
        end
        // storage pointer runs on across entries and wraps at the top
        ptr_next  = ptr_reg + 1'b1;
        addr_next = addr_reg + 16'h0001;
        if (cnt_reg == 7'h00)
        begin
          state_next = ESL_CMD;
        end
        else
        begin
          cnt_next   = cnt_reg - 7'h01;
          state_next = ESL_RD;
        end
      end
    endcase
    busy_next = (state_next != ESL_IDLE);
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ESL_IDLE;
      load_reg  <= 1'b0;
      idx_reg   <= 8'h00;
      cnt_reg   <= 7'h00;
      addr_reg  <= 16'h0000;
      ptr_reg   <= '0;
      cfg_reg   <= '0;
      nvm_reg   <= '0;
      busy_reg  <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      load_reg  <= load_next;
      idx_reg   <= idx_next;
      cnt_reg   <= cnt_next;
      addr_reg  <= addr_next;
      ptr_reg   <= ptr_next;
      cfg_reg   <= cfg_next;
      nvm_reg   <= nvm_next;
      busy_reg  <= busy_next;
      rdata_reg <= rdata_next;
    end
  end

  // every output leaves straight from a flop, no logic after it
  assign rdata   = rdata_reg;
  assign cfg_req = cfg_reg;
  assign nvm_req = nvm_reg;
  assign busy    = busy_reg;

endmodule : esl_loader

// [hw/esl_pkg.sv]
package esl_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [11:0] ESL_ADDR_UPDATE  = 12'h232;
  localparam logic [11:0] ESL_ADDR_TBL_LO  = 12'hA00;
  localparam logic [11:0] ESL_ADDR_TBL_HI  = 12'hAFF;
  localparam logic [11:0] ESL_ADDR_STATUS  = 12'hB00;
  localparam logic [11:0] ESL_ADDR_SAVE    = 12'hB03;
  localparam logic [11:0] ESL_ADDR_LOAD    = 12'hB04;
  localparam int          ESL_BIT_FLAG     = 0;

  // ************************************************************
  // command bytes
  // ************************************************************
  localparam int          ESL_BIT_OPCODE   = 7;
  localparam logic [7:0]  ESL_OP_APPLY     = 8'h80;
  localparam logic [7:0]  ESL_OP_END       = 8'hFF;
  localparam logic [7:0]  ESL_TBL_LAST     = 8'hFF;
  localparam int          ESL_TBL_DEPTH    = 256;
  localparam int          ESL_NVM_AW       = 10;

  // power-on table: registers 0x000..0x232, then apply, then end
  localparam int          ESL_DEF_LEN      = 17;
  localparam logic [7:0]  ESL_DEF_TBL [ESL_DEF_LEN] = '{
    8'h7F, 8'h00, 8'h00,
    8'h7F, 8'h00, 8'h80,
    8'h7F, 8'h01, 8'h00,
    8'h7F, 8'h01, 8'h80,
    8'h32, 8'h02, 8'h00,
    8'h80, 8'hFF
  };

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } esl_bus_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } esl_cfg_t;

  typedef struct packed {
    logic [ESL_NVM_AW-1:0] addr;
    logic [7:0]            wdata;
    logic                  we;
    logic                  re;
  } esl_nvm_t;

  typedef enum logic [2:0] {
    ESL_IDLE,
    ESL_CMD,
    ESL_AHI,
    ESL_ALO,
    ESL_RD,
    ESL_WAIT,
    ESL_WR
  } esl_state_t;

  function automatic logic [7:0] esl_def_byte(input int idx);
    if (idx < ESL_DEF_LEN)
    begin
      return ESL_DEF_TBL[idx];
    end
    return ESL_OP_END;
  endfunction : esl_def_byte

endpackage : esl_pkg

// [hw/esl_seg_table.sv]
`timescale 1ns/100ps
module esl_seg_table
  import esl_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // host write
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  // two read ports
  input  wire logic [7:0] raddr_a,
  output logic      [7:0] rdata_a,
  input  wire logic [7:0] raddr_b,
  output logic      [7:0] rdata_b
);
  import esl_pkg::*;

  logic [7:0] mem_reg [ESL_TBL_DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < ESL_TBL_DEPTH; gi++)
    begin : g_ent
      logic [7:0] ent_next;
      always_comb
      begin
        ent_next = mem_reg[gi];
        if (we && (waddr == 8'(gi)))
        begin
          ent_next = wdata;
        end
      end
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          mem_reg[gi] <= esl_def_byte(gi);
        end
        else
        begin
          mem_reg[gi] <= ent_next;
        end
      end
    end
  endgenerate

  assign rdata_a = mem_reg[raddr_a];
  assign rdata_b = mem_reg[raddr_b];

endmodule : esl_seg_table

// [hw/esl_update_ctl.sv]
`timescale 1ns/100ps
module esl_update_ctl
  import esl_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // requests
  input  wire logic sw_set,
  input  wire logic seq_set,
  // one-cycle copy strobe for the active registers
  output logic      apply_pulse
);
  import esl_pkg::*;

  logic apply_reg;
  logic apply_next;

  // ************************************************************
  // self-clearing copy strobe
  // ************************************************************
  always_comb
  begin
    // high for one edge only; no write of zero needed
    apply_next = sw_set | seq_set;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      apply_reg <= 1'b0;
    end
    else
    begin
      apply_reg <= apply_next;
    end
  end

  assign apply_pulse = apply_reg;

endmodule : esl_update_ctl

// [verif/esl_loader_asserts.sv]
`timescale 1ns/100ps
module esl_loader_asserts
  import esl_pkg::*;
(
  // clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  // register port
  input wire esl_pkg::esl_bus_t bus,
  input wire logic [7:0]        rdata,
  // far side
  input wire esl_pkg::esl_cfg_t cfg_req,
  input wire logic [7:0]        cfg_rdata,
  input wire logic              update_pulse,
  input wire esl_pkg::esl_nvm_t nvm_req,
  input wire logic [7:0]        nvm_rdata,
  // status
  input wire logic              busy
);
  // ****
  // checks
  // ****
  logic upd_wr;
  assign upd_wr = bus.we && bus.addr == ESL_ADDR_UPDATE && bus.wdata[0];

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  upd_next_a:
  assert property (upd_wr |=> update_pulse) else $error("update pulse missing");
  upd_clear_a:
  assert property (update_pulse && !busy && !upd_wr |=> !update_pulse)
    else $error("update pulse too long");
  upd_cause_a:
  assert property (update_pulse && !$past(busy) |-> $past(upd_wr))
    else $error("update pulse without request");
  xfer_start_a:
  assert property (bus.we && bus.wdata[0] && !busy
    && (bus.addr == ESL_ADDR_SAVE || bus.addr == ESL_ADDR_LOAD) |=> busy)
    else $error("transfer did not start");
  stat_read_a:
  assert property ((bus.re && bus.addr == ESL_ADDR_STATUS && busy) ##1 busy |-> rdata == 8'h01)
    else $error("status misread");
  rd_idle_a:
  assert property (!$past(bus.re) |-> rdata == 8'h00) else $error("read data outside slot");
  idle_quiet_a:
  assert property (!busy |-> !(cfg_req.re || cfg_req.we || nvm_req.re || nvm_req.we))
    else $error("access after end of walk");
  save_copy_a:
  assert property (cfg_req.re |-> ##2 nvm_req.we && nvm_req.wdata == $past(cfg_rdata))
    else $error("save byte lost");
  load_copy_a:
  assert property (nvm_req.re |-> ##2 cfg_req.we && cfg_req.wdata == $past(nvm_rdata))
    else $error("restore byte lost");
endmodule : esl_loader_asserts

bind esl_loader esl_loader_asserts u_esl_loader_asserts (
  .mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .cfg_req(cfg_req),
  .cfg_rdata(cfg_rdata), .update_pulse(update_pulse), .nvm_req(nvm_req),
  .nvm_rdata(nvm_rdata), .busy(busy));

// [verif/esl_far_model.sv]
`timescale 1ns/100ps
module esl_far_model
  import esl_pkg::*;
(
  // clock
  input  wire logic              mclk,
  // register space and storage
  input  wire esl_pkg::esl_cfg_t cfg_req,
  output logic [7:0]             cfg_rdata,
  input  wire esl_pkg::esl_nvm_t nvm_req,
  output logic [7:0]             nvm_rdata
);
  logic [7:0] cfg_mem [4096];
  logic [7:0] nvm_mem [1024];

  initial
  begin
    cfg_rdata = 8'h00;
    nvm_rdata = 8'h00;
    for (int i = 0; i < 4096; i++) cfg_mem[i] = 8'(i) ^ 8'h5A;
    for (int i = 0; i < 1024; i++) nvm_mem[i] = 8'h00;
  end

  // idle data toggles so stale bytes never look valid
  always @(posedge mclk)
  begin
    if (cfg_req.we) cfg_mem[cfg_req.addr] <= cfg_req.wdata;
    if (nvm_req.we) nvm_mem[nvm_req.addr] <= nvm_req.wdata;
    cfg_rdata <= cfg_req.re ? cfg_mem[cfg_req.addr] : ~cfg_rdata;
    nvm_rdata <= nvm_req.re ? nvm_mem[nvm_req.addr] : ~nvm_rdata;
  end
endmodule : esl_far_model

// [verif/esl_loader_tb.sv]
`timescale 1ns/100ps
module esl_loader_tb;
  import esl_pkg::*;
  logic       mclk;
  logic       rst_n;
  esl_bus_t   bus;
  esl_cfg_t   cfg_req;
  esl_nvm_t   nvm_req;
  logic [7:0] rdata;
  logic [7:0] cfg_rdata;
  logic [7:0] nvm_rdata;
  logic       update_pulse;
  logic       busy;
  int         err_count;
  int         cmp_count;
  int         upd_cnt;
  int         u0;
  logic [7:0] v;
  logic [7:0] def_tbl [17] = '{8'h7F, 8'h00, 8'h00, 8'h7F, 8'h00, 8'h80, 8'h7F, 8'h01,
    8'h00, 8'h7F, 8'h01, 8'h80, 8'h32, 8'h02, 8'h00, 8'h80, 8'hFF};
  // two bytes at 0x010, apply, one byte at 0x123, end
  logic [7:0] my_tbl [8] = '{8'h01, 8'h00, 8'h10, 8'h80, 8'h00, 8'h01, 8'h23, 8'hFF};

  esl_loader u_esl_loader (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .update_pulse(update_pulse),
    .nvm_req(nvm_req), .nvm_rdata(nvm_rdata), .busy(busy));
  esl_far_model u_esl_far_model (.mclk(mclk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .nvm_req(nvm_req), .nvm_rdata(nvm_rdata));

  // ****
  // bus tasks
  // ****
  always #4 mclk = ~mclk;
  always @(posedge mclk) if (update_pulse === 1'b1) upd_cnt++;

  task chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask : wr

  task rd(input logic [11:0] a);
    @(posedge mclk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1 v = rdata;
  endtask : rd

  task wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000)
    begin
      @(posedge mclk);
      #1 n++;
    end
    if (n >= 5000) err_count++;
  endtask : wait_idle

  task wrap_up;
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // ****
  // tests
  // ****
  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    bus = '0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 17; i++)
    begin
      rd(12'hA00 + 12'(i));
      chk(v, def_tbl[i]);
    end
    rd(12'hAFF);
    chk(v, 8'hFF);
    rd(ESL_ADDR_STATUS);
    chk(v, 8'h00);
    rd(12'h100);
    chk(v, 8'h00);
    $display("test reset contents done");
    wr(ESL_ADDR_UPDATE, 8'h00);
    #1 chk({7'h00, update_pulse}, 8'h00);
    wr(ESL_ADDR_UPDATE, 8'h01);
    #1 chk({7'h00, update_pulse}, 8'h01);
    @(posedge mclk);
    #1 chk({7'h00, update_pulse}, 8'h00);
    rd(ESL_ADDR_UPDATE);
    chk(v, 8'h00);
    $display("test update bit done");
    for (int i = 0; i < 8; i++) wr(12'hA00 + 12'(i), my_tbl[i]);
    wr(12'hAFF, 8'hFF);
    rd(12'hA03);
    chk(v, 8'h80);
    u0 = upd_cnt;
    wr(ESL_ADDR_SAVE, 8'h01);
    rd(ESL_ADDR_STATUS);
    chk(v, 8'h01);
    rd(ESL_ADDR_SAVE);
    chk(v, 8'h01);
    wait_idle();
    chk(u_esl_far_model.nvm_mem[0], 8'h10 ^ 8'h5A);
    chk(u_esl_far_model.nvm_mem[1], 8'h11 ^ 8'h5A);
    chk(u_esl_far_model.nvm_mem[2], 8'h23 ^ 8'h5A);
    chk(u_esl_far_model.nvm_mem[3], 8'h00);
    chk(8'(upd_cnt - u0), 8'h01);
    rd(ESL_ADDR_STATUS);
    chk(v, 8'h00);
    $display("test save done");
    repeat (1250) @(posedge mclk);
    u_esl_far_model.nvm_mem[0] = 8'hC1;
    u_esl_far_model.nvm_mem[1] = 8'hC2;
    u_esl_far_model.nvm_mem[2] = 8'hC3;
    u0 = upd_cnt;
    wr(ESL_ADDR_LOAD, 8'h01);
    rd(ESL_ADDR_LOAD);
    chk(v, 8'h01);
    wr(ESL_ADDR_SAVE, 8'h01);
    rd(ESL_ADDR_SAVE);
    chk(v, 8'h00);
    wait_idle();
    chk(u_esl_far_model.cfg_mem[12'h010], 8'hC1);
    chk(u_esl_far_model.cfg_mem[12'h011], 8'hC2);
    chk(u_esl_far_model.cfg_mem[12'h123], 8'hC3);
    chk(u_esl_far_model.cfg_mem[12'h012], 8'h12 ^ 8'h5A);
    chk(8'(upd_cnt - u0), 8'h01);
    $display("test restore done");
    wrap_up();
  end

  // run should take about 1400 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    wrap_up();
  end
endmodule : esl_loader_tb
